// ### bench/rximb_assertions.sv
// Port checker for the receive interrupt mask bank.
// Assumes a bind onto rximb_top and one core_clk domain.
`timescale 1ns/1ps
module rximb_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status in, interrupts out
  input wire logic [7:0] e1_mode,
  input wire logic [7:0][7:0] lat_alarm,
  input wire logic irq_out_n,
  input wire logic bank_irq,
  input wire logic [7:0][7:0] rx_interrupt_summary
);
  // One domain, so clock and reset given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("setup not answered next cycle");
  AST_UNMAPPED: assert property (psel && !penable && paddr[13:2] == 12'h0A5 |=> pslverr)
    else $error("unmapped access not refused");
  AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_IRQ_SUM: assert property (irq_out_n == (rx_interrupt_summary == 64'h0))
    else $error("interrupt out disagrees with summary");
  AST_GATE: assert property (lat_alarm[0] == 8'h00 |=> !rx_interrupt_summary[0][0])
    else $error("summary set with no latched event");
  AST_T1_QUIET: assert property (!e1_mode[0] |=> !rx_interrupt_summary[0][1])
    else $error("second status interrupts in T1");
  AST_SUM_RSVD: assert property ((rx_interrupt_summary & 64'hA0A0A0A0A0A0A0A0) == 64'h0)
    else $error("reserved summary bit set");
  AST_RESET: assert property ($fell(srst) |-> irq_out_n && !bank_irq)
    else $error("interrupt active out of reset");
  // Main scenarios reached
  cover property (!irq_out_n);
  cover property (bank_irq);
  cover property (pslverr);
endmodule

// ### bench/tb.sv
// Self-checking bench for the receive interrupt mask bank.
// Assumes rximb_top answers APB with zero wait states.
`timescale 1ns/1ps
module tb;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, irq_out_n, bank_irq, er;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] e1_mode;
  logic [7:0][7:0] la [6];
  logic [7:0][7:0] rx_interrupt_summary, es;
  logic [7:0] m [8][6];
  int fails, num_checks;
  rximb_top uut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .e1_mode, .lat_alarm(la[0]), .lat_framing(la[1]),
    .lat_code_clock(la[2]), .lat_elastic(la[3]), .lat_hdlc(la[4]), .lat_boc_fdl(la[5]),
    .irq_out_n, .bank_irq, .rx_interrupt_summary);
  // 50 ns clock
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  // Implemented bits of each slot by line mode
  function automatic logic [7:0] bits(int s, logic e);
    case (s)
      0: return 8'hFF;
      1: return e ? 8'h0F : 8'h00;
      2: return e ? 8'hBB : 8'hFF;
      3: return 8'hEF;
      4: return 8'h3F;
      default: return e ? 8'h03 : 8'h3F;
    endcase
  endfunction
  function automatic logic [11:0] ix(int p, int s);
    return 12'(p * 'h200 + (s < 5 ? 'hA0 + s : 'hA6));
  endfunction
  // Summary bit of slot s is the OR of status AND mask
  function automatic logic [63:0] expsum();
    logic [7:0][7:0] r;
    r = '0;
    for (int p = 0; p < 8; p++) for (int s = 0; s < 6; s++)
      r[p][s < 5 ? s : 6] = |(la[s][p] & m[p][s]);
    return r;
  endfunction
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer; the idle edge first keeps psel from two writes in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 16) begin
      fails++;
      stop_test();
    end
  endtask
  initial begin
    srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    e1_mode = 8'h5A; fails = 0; num_checks = 0;
    for (int s = 0; s < 6; s++) la[s] = '1;
    void'($urandom(32'h71a9d47f));
    repeat (20) @(posedge core_clk);
    srst <= 0;
    // All events latched, all masks fresh from reset
    for (int p = 0; p < 8; p++) for (int s = 0; s < 6; s++) begin
      apb(0, ix(p, s), 0);
      chk(rd, 0);
    end
    chk(rx_interrupt_summary, 0);
    chk(irq_out_n, 1);
    $display("test reset values done");
    // Port 8 gets all ones so unused bits are exercised; read after all writes
    for (int p = 0; p < 8; p++) for (int s = 0; s < 6; s++) begin
      m[p][s] = p == 7 ? 8'hFF : 8'($urandom);
      apb(1, ix(p, s), m[p][s]);
      m[p][s] &= bits(s, e1_mode[p]);
    end
    for (int p = 0; p < 8; p++) for (int s = 0; s < 6; s++) begin
      apb(0, ix(p, s), 0);
      chk(rd, m[p][s]);
      chk(er, 0);
    end
    apb(1, 12'h0A5, 8'hFF);
    chk(er, 1);
    apb(0, 12'h0A5, 0);
    chk(rd, 0);
    $display("test registers done");
    // Sparse random events against the stored masks
    repeat (30) begin
      for (int s = 0; s < 6; s++) for (int p = 0; p < 8; p++) la[s][p] <= 8'($urandom & $urandom);
      repeat (2) @(posedge core_clk);
      es = expsum();
      chk(rx_interrupt_summary, es);
      chk(irq_out_n, es == 0);
    end
    $display("test gating done");
    // Bank status: clear, raise one port, mask, clear again
    for (int s = 0; s < 6; s++) la[s] <= '0;
    apb(1, 12'h001, 8'hFF);
    apb(1, 12'h000, 8'hFF);
    apb(0, 12'h000, 0);
    chk(rd, 0);
    apb(1, ix(2, 0), 8'h01);
    la[0][2] <= 8'h01;
    repeat (4) @(posedge core_clk);
    chk(bank_irq, 1);
    apb(0, 12'h000, 0);
    chk(rd, 32'h4);
    apb(1, 12'h001, 8'h00);
    repeat (2) @(posedge core_clk);
    chk(bank_irq, 0);
    apb(1, 12'h000, 8'h04);
    apb(0, 12'h000, 0);
    chk(rd, 0);
    $display("test bank interrupt done");
    stop_test();
  end
endmodule
bind rximb_top rximb_assertions chk_i (.core_clk, .srst, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .e1_mode, .lat_alarm, .irq_out_n, .bank_irq, .rx_interrupt_summary);

// ### hw/rximb_pkg.sv
// Package for the receive interrupt mask bank: register indices, field layouts, resets.
// Assumes an APB slave with 32-bit words, each register index at byte address index*4.
package rximb_pkg;
  // Mask register indices within one port window (byte address = index * 4)
  localparam logic [8:0] ALARM_IDX = 9'h0A0;
  localparam logic [8:0] FRAMING_IDX = 9'h0A1;
  localparam logic [8:0] CODE_CLOCK_IDX = 9'h0A2;
  localparam logic [8:0] ELASTIC_IDX = 9'h0A3;
  localparam logic [8:0] HDLC_IDX = 9'h0A4;
  localparam logic [8:0] BOC_FDL_IDX = 9'h0A6;
  // Port windows repeat every 200h indices; port field is index bits 11:9
  localparam logic [11:0] PORT_STRIDE = 12'h200;
  localparam int PORT_LSB = 9;
  localparam int NUM_PORTS = 8;
  localparam int NUM_SLOTS = 6;
  localparam logic [2:0] NO_SLOT = 3'h7;
  // Bank-level interrupt registers (indices in the port 1 window, below the masks)
  localparam logic [11:0] IRQ_STATUS_IDX = 12'h000;
  localparam logic [11:0] IRQ_MASK_IDX = 12'h001;
  // Implemented bits per slot, by line mode
  localparam logic [7:0] ALARM_BITS = 8'hFF;
  localparam logic [7:0] FRAMING_BITS_E1 = 8'h0F;
  localparam logic [7:0] FRAMING_BITS_T1 = 8'h00;
  localparam logic [7:0] CODE_CLOCK_BITS_T1 = 8'hFF;
  localparam logic [7:0] CODE_CLOCK_BITS_E1 = 8'hBB;
  localparam logic [7:0] ELASTIC_BITS = 8'hEF;
  localparam logic [7:0] HDLC_BITS = 8'h3F;
  localparam logic [7:0] BOC_FDL_BITS_T1 = 8'h3F;
  localparam logic [7:0] BOC_FDL_BITS_E1 = 8'h03;
  // Summary bit that each slot drives (bit 5 reserved, bit 7 unused)
  localparam logic [2:0] SUM_ALARM = 3'h0;
  localparam logic [2:0] SUM_FRAMING = 3'h1;
  localparam logic [2:0] SUM_CODE_CLOCK = 3'h2;
  localparam logic [2:0] SUM_ELASTIC = 3'h3;
  localparam logic [2:0] SUM_HDLC = 3'h4;
  localparam logic [2:0] SUM_BOC_FDL = 3'h6;
  // Values after reset
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;
endpackage

// ### hw/rximb_top.sv
// Receive interrupt mask bank for eight framer ports, with an APB register slave.
// Assumes latched status inputs come from the framer's status registers on core_clk;
// this bank only gates them and never alters them.
`timescale 1ns/1ps
module rximb_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line mode per port, 1 = E1, 0 = T1
  input wire logic [7:0] e1_mode,
  // Latched receive status per port
  input wire logic [7:0][7:0] lat_alarm,
  input wire logic [7:0][7:0] lat_framing,
  input wire logic [7:0][7:0] lat_code_clock,
  input wire logic [7:0][7:0] lat_elastic,
  input wire logic [7:0][7:0] lat_hdlc,
  input wire logic [7:0][7:0] lat_boc_fdl,
  // Interrupt outputs
  output logic irq_out_n,
  output logic bank_irq,
  output logic [7:0][7:0] rx_interrupt_summary
);

  // Map a window index onto a mask slot
  function automatic logic [2:0] slot_of(input logic [8:0] off);
    case (off)
      rximb_pkg::ALARM_IDX: slot_of = 3'h0;
      rximb_pkg::FRAMING_IDX: slot_of = 3'h1;
      rximb_pkg::CODE_CLOCK_IDX: slot_of = 3'h2;
      rximb_pkg::ELASTIC_IDX: slot_of = 3'h3;
      rximb_pkg::HDLC_IDX: slot_of = 3'h4;
      rximb_pkg::BOC_FDL_IDX: slot_of = 3'h5;
      default: slot_of = rximb_pkg::NO_SLOT;
    endcase
  endfunction

  // Implemented bits of a slot in the given line mode
  function automatic logic [7:0] valid_bits(input logic [2:0] slot, input logic e1);
    case (slot)
      3'h0: valid_bits = rximb_pkg::ALARM_BITS;
      3'h1: valid_bits = e1 ? rximb_pkg::FRAMING_BITS_E1 : rximb_pkg::FRAMING_BITS_T1;
      3'h2: valid_bits = e1 ? rximb_pkg::CODE_CLOCK_BITS_E1
                            : rximb_pkg::CODE_CLOCK_BITS_T1;
      3'h3: valid_bits = rximb_pkg::ELASTIC_BITS;
      3'h4: valid_bits = rximb_pkg::HDLC_BITS;
      3'h5: valid_bits = e1 ? rximb_pkg::BOC_FDL_BITS_E1 : rximb_pkg::BOC_FDL_BITS_T1;
      default: valid_bits = 8'h00;
    endcase
  endfunction

  // Summary bit position driven by a slot
  function automatic logic [2:0] sum_bit(input logic [2:0] slot);
    case (slot)
      3'h0: sum_bit = rximb_pkg::SUM_ALARM;
      3'h1: sum_bit = rximb_pkg::SUM_FRAMING;
      3'h2: sum_bit = rximb_pkg::SUM_CODE_CLOCK;
      3'h3: sum_bit = rximb_pkg::SUM_ELASTIC;
      3'h4: sum_bit = rximb_pkg::SUM_HDLC;
      default: sum_bit = rximb_pkg::SUM_BOC_FDL;
    endcase
  endfunction

  // Mask registers, one array per register, indexed by port
  logic [7:0] rx_alarm_condition_mask_q [0:7];
  logic [7:0] rx_e1_framing_event_mask_q [0:7];
  logic [7:0] rx_code_clock_event_mask_q [0:7];
  logic [7:0] rx_elastic_timer_event_mask_q [0:7];
  logic [7:0] rx_hdlc_event_mask_q [0:7];
  logic [7:0] rx_boc_fdl_event_mask_q [0:7];
  // Same words gathered by slot for the shared read and gating paths
  logic [7:0] mask_word [0:7][0:5];
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic [7:0] port_req_q;
  logic [7:0][7:0] summary_d;
  logic [7:0] port_req_d;
  logic [31:0] prdata_d;
  logic [7:0] stat_word;

  // Address decode: index bits 11:9 pick the port, 8:0 the register
  wire logic [11:0] reg_idx = paddr[13:2];
  wire logic [2:0] acc_port = reg_idx[11:rximb_pkg::PORT_LSB];
  wire logic [2:0] acc_slot = slot_of(reg_idx[8:0]);
  wire logic slot_hit = acc_slot != rximb_pkg::NO_SLOT;
  wire logic stat_hit = reg_idx == rximb_pkg::IRQ_STATUS_IDX;
  wire logic imask_hit = reg_idx == rximb_pkg::IRQ_MASK_IDX;
  wire logic any_hit = slot_hit | stat_hit | imask_hit;
  wire logic [7:0] acc_valid = valid_bits(acc_slot, e1_mode[acc_port]);
  wire logic [2:0] rd_slot = slot_hit ? acc_slot : 3'h0;
  wire logic [7:0] mask_rd = mask_word[acc_port][rd_slot] & acc_valid;
  wire logic setup_ph = psel & ~penable;
  wire logic wr_en = psel & penable & pwrite & pready & ~pslverr;
  // One-hot write strobes; a stray slot code is harmless since slot_hit gates the port
  wire logic [7:0] wr_port = (wr_en & slot_hit) ? (8'h01 << acc_port) : 8'h00;
  wire logic [5:0] wr_slot = 6'h01 << acc_slot;
  wire logic [7:0] wr_byte = pwdata[7:0] & acc_valid;
  // Write-one-to-clear lands only on the bank status register
  wire logic [7:0] stat_clr = (wr_en & stat_hit) ? pwdata[7:0] : 8'h00;
  wire logic [7:0] req_rise = port_req_d & ~port_req_q;

  // Read data is prepared in the setup cycle so the answer comes from a flop
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (slot_hit) begin
      prdata_d[7:0] = mask_rd;
    end else if (stat_hit) begin
      prdata_d[7:0] = irq_status_q;
    end else if (imask_hit) begin
      prdata_d[7:0] = irq_mask_q;
    end
  end

  // Gate each latched status word by its effective mask
  always_comb begin
    summary_d = '0;
    port_req_d = 8'h00;
    stat_word = 8'h00;
    for (int p = 0; p < rximb_pkg::NUM_PORTS; p++) begin
      for (int s = 0; s < rximb_pkg::NUM_SLOTS; s++) begin
        case (s)
          0: stat_word = lat_alarm[p];
          1: stat_word = lat_framing[p];
          2: stat_word = lat_code_clock[p];
          3: stat_word = lat_elastic[p];
          4: stat_word = lat_hdlc[p];
          default: stat_word = lat_boc_fdl[p];
        endcase
        // Stale bits from the other mode stay gated off
        summary_d[p][sum_bit(3'(s))] =
          |(stat_word & mask_word[p][s] & valid_bits(3'(s), e1_mode[p]));
      end
      port_req_d[p] = |summary_d[p];
    end
  end

  // Gather the named registers by slot; slot numbers follow slot_of
  always_comb begin
    for (int p = 0; p < rximb_pkg::NUM_PORTS; p++) begin
      mask_word[p][0] = rx_alarm_condition_mask_q[p];
      mask_word[p][1] = rx_e1_framing_event_mask_q[p];
      mask_word[p][2] = rx_code_clock_event_mask_q[p];
      mask_word[p][3] = rx_elastic_timer_event_mask_q[p];
      mask_word[p][4] = rx_hdlc_event_mask_q[p];
      mask_word[p][5] = rx_boc_fdl_event_mask_q[p];
    end
  end

  // Alarm condition masks: detect enables low, clear enables high
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < rximb_pkg::NUM_PORTS; p++) begin
      if (srst) begin
        rx_alarm_condition_mask_q[p] <= rximb_pkg::MASK_RESET;
      end else if (wr_port[p] && wr_slot[0]) begin
        rx_alarm_condition_mask_q[p] <= wr_byte;
      end
    end
  end

  // Framing event masks; a T1 port keeps this word at zero
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < rximb_pkg::NUM_PORTS; p++) begin
      if (srst) begin
        rx_e1_framing_event_mask_q[p] <= rximb_pkg::MASK_RESET;
      end else if (wr_port[p] && wr_slot[1]) begin
        rx_e1_framing_event_mask_q[p] <= wr_byte;
      end
    end
  end

  // Code and clock masks; layout depends on the port's line mode
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < rximb_pkg::NUM_PORTS; p++) begin
      if (srst) begin
        rx_code_clock_event_mask_q[p] <= rximb_pkg::MASK_RESET;
      end else if (wr_port[p] && wr_slot[2]) begin
        rx_code_clock_event_mask_q[p] <= wr_byte;
      end
    end
  end

  // Elastic store and timer masks; bit 4 never holds a one
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < rximb_pkg::NUM_PORTS; p++) begin
      if (srst) begin
        rx_elastic_timer_event_mask_q[p] <= rximb_pkg::MASK_RESET;
      end else if (wr_port[p] && wr_slot[3]) begin
        rx_elastic_timer_event_mask_q[p] <= wr_byte;
      end
    end
  end

  // HDLC receive masks, six low bits
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < rximb_pkg::NUM_PORTS; p++) begin
      if (srst) begin
        rx_hdlc_event_mask_q[p] <= rximb_pkg::MASK_RESET;
      end else if (wr_port[p] && wr_slot[4]) begin
        rx_hdlc_event_mask_q[p] <= wr_byte;
      end
    end
  end

  // Code and data link masks; an E1 port keeps only the two low bits
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < rximb_pkg::NUM_PORTS; p++) begin
      if (srst) begin
        rx_boc_fdl_event_mask_q[p] <= rximb_pkg::MASK_RESET;
      end else if (wr_port[p] && wr_slot[5]) begin
        rx_boc_fdl_event_mask_q[p] <= wr_byte;
      end
    end
  end

  // APB answer: zero wait states, error on an unmapped index
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~any_hit;
      if (setup_ph) begin
        prdata <= prdata_d;
      end
    end
  end

  // Bank status: a port request rising is sticky; set beats a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_status_q <= rximb_pkg::BANK_RESET;
    end else begin
      irq_status_q <= (irq_status_q & ~stat_clr) | req_rise;
    end
  end

  // Last cycle's port requests; zero after reset, as all masks start closed
  always_ff @(posedge core_clk) begin
    if (srst) begin
      port_req_q <= 8'h00;
    end else begin
      port_req_q <= port_req_d;
    end
  end

  // Bank interrupt mask, all eight bits live
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_mask_q <= rximb_pkg::BANK_RESET;
    end else if (wr_en && imask_hit) begin
      irq_mask_q <= pwdata[7:0];
    end
  end

  // Line interrupt: low while any port holds an unmasked pending event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~(|port_req_d);
    end
  end

  // Bank interrupt follows the status as it stands after this edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bank_irq <= 1'b0;
    end else begin
      bank_irq <= |(((irq_status_q & ~stat_clr) | req_rise) & irq_mask_q);
    end
  end

  // Summary registered so it moves in the same cycle as the line interrupt
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_interrupt_summary <= '0;
    end else begin
      rx_interrupt_summary <= summary_d;
    end
  end

endmodule
